// ### design/scurve_pkg.sv
`default_nettype none
package scurve_pkg;
    // Bus map, byte addresses
    localparam logic [5:0] CONTROL_ADDR     = 6'h00;
    localparam logic [5:0] ACCEL_ADDR       = 6'h04;
    localparam logic [5:0] DECEL_ADDR       = 6'h08;
    localparam logic [5:0] JERK_ADDR        = 6'h0C;
    localparam logic [5:0] START_SPEED_ADDR = 6'h10;
    localparam logic [5:0] TARGET_ADDR      = 6'h14;
    localparam logic [5:0] STATUS_ADDR      = 6'h18;
    localparam logic [5:0] SPEED_ADDR       = 6'h1C;
    localparam logic [5:0] ACCEL_NOW_ADDR   = 6'h20;

    localparam int CONTROL_GO_BIT   = 0;
    localparam int STATUS_BUSY_BIT  = 0;
    localparam int STATUS_DECEL_BIT = 1;
    localparam int STATUS_PHASE_LSB = 4;

    localparam int RATE_W  = 16;
    localparam int JERK_W  = 16;
    localparam int SPEED_W = 24;
    localparam int FINE_W  = 48;
    localparam int JINC_W  = 32;

    localparam logic [RATE_W-1:0]  ACCEL_RESET  = 16'h0014;
    localparam logic [RATE_W-1:0]  DECEL_RESET  = 16'h0019;
    localparam logic [JERK_W-1:0]  JERK_RESET   = 16'h0000;
    localparam logic [SPEED_W-1:0] START_RESET  = 24'h00008D;
    localparam logic [SPEED_W-1:0] TARGET_RESET = 24'h000000;

    // Jerk scale limits and its divisor
    localparam logic [JERK_W-1:0] JERK_MAX     = 16'h1388;
    localparam int                JERK_DIVISOR = 100;
    // Rates are steps/s per ms, i.e. one unit is 1000 steps/s^2
    localparam int                RATE_PER_SEC = 1000;
    // Fine fraction: one step/s of speed per tick is this many fine units
    localparam int                FINE_SCALE   = JERK_DIVISOR * RATE_PER_SEC;

    // Profile tick, one millisecond
    localparam int CLK_PERIOD_NS       = 10;
    localparam int TICK_TIME_NS        = 1000000;
    localparam int TICK_CYCLES_DEFAULT = TICK_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {PH_IDLE, PH_JERK_UP, PH_HOLD, PH_JERK_DOWN} phase_type;

    typedef struct packed {
        logic [RATE_W-1:0] rate;
        logic [JERK_W-1:0] jerk;
    } shape_type;

    typedef struct packed {
        logic [FINE_W-1:0] accel_limit;
        logic [JINC_W-1:0] jerk_inc;
        logic              constant;
    } ramp_type;
endpackage : scurve_pkg
`default_nettype wire

// ### design/jerk_rate_calc.sv
`default_nettype none
module jerk_rate_calc (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire scurve_pkg::shape_type shape,
    output scurve_pkg::ramp_type       ramp
);
    logic [scurve_pkg::JERK_W-1:0] jerk_clamped;
    scurve_pkg::ramp_type          next_ramp;

    always_comb begin
        jerk_clamped = (shape.jerk > scurve_pkg::JERK_MAX) ? scurve_pkg::JERK_MAX : shape.jerk;
        // jerk from scale and rate
        // Per tick the accel grows by J*a/100 steps/s^2 * 1 ms, held in fine units
        next_ramp.jerk_inc    = scurve_pkg::JINC_W'(jerk_clamped) * scurve_pkg::JINC_W'(shape.rate);
        next_ramp.accel_limit = scurve_pkg::FINE_W'(shape.rate) * scurve_pkg::FINE_W'(scurve_pkg::FINE_SCALE);
        next_ramp.constant    = (jerk_clamped == '0);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ramp <= '0;
        end else begin
            ramp <= next_ramp;
        end
    end
endmodule : jerk_rate_calc
`default_nettype wire

// ### design/scurve_jerk_accel_profiler.sv
// Functional notes
// - Jerk scale 1..5000 ramps acceleration gradually, giving an S-shaped speed curve.
// - Jerk rate equals scale divided by 100 times programmed acceleration.
// - Jerk rate spans 0.01 to 50 times the programmed acceleration.
// - Deceleration uses the same scaling with the programmed deceleration value.
// - Jerk scale zero gives constant acceleration and linear speed change.
// - Ramp accel toward limit; hold if reached before midpoint, else triangular.
// - Scale 200/t gives exact triangle; lower lengthens, higher makes trapezoid.
// - Scale 400/t gives constant accel over half the phase.
// - Phases start and end smoothly; no square-root starting speed needed.
// - Rates are in steps per second per millisecond.
// - Phases are symmetrical about the speed change midpoint.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`default_nettype none
module scurve_jerk_accel_profiler #(
    parameter int TICK_CYCLES = scurve_pkg::TICK_CYCLES_DEFAULT
) (
    input  wire logic                            clk_sys,
    input  wire logic                            reset,
    input  wire logic [5:0]                      avs_address,
    input  wire logic                            avs_read,
    input  wire logic                            avs_write,
    input  wire logic [31:0]                     avs_writedata,
    input  wire logic [3:0]                      avs_byteenable,
    output logic [31:0]                          avs_readdata,
    output logic                                 avs_waitrequest,
    output logic [scurve_pkg::SPEED_W-1:0]       speed_cmd,
    output logic                                 busy
);
    // Register file
    logic [scurve_pkg::RATE_W-1:0]  accel_rate, next_accel_rate;
    logic [scurve_pkg::RATE_W-1:0]  decel_rate, next_decel_rate;
    logic [scurve_pkg::JERK_W-1:0]  jerk_scale, next_jerk_scale;
    logic [scurve_pkg::SPEED_W-1:0] start_speed, next_start_speed;
    logic [scurve_pkg::SPEED_W-1:0] target_speed, next_target_speed;
    logic                           ack, next_ack;
    logic [31:0]                    next_readdata;
    logic                           go;

    // Profile engine
    scurve_pkg::phase_type          phase, next_phase;
    logic                           decel_dir, next_decel_dir;
    logic [scurve_pkg::FINE_W-1:0]  accel_fine, next_accel_fine;
    logic [scurve_pkg::FINE_W-1:0]  progress, next_progress;
    logic [scurve_pkg::FINE_W-1:0]  delta_fine, next_delta_fine;
    logic [scurve_pkg::FINE_W-1:0]  ramp_gain, next_ramp_gain;
    logic [scurve_pkg::SPEED_W-1:0] base_speed, next_base_speed;
    logic [scurve_pkg::SPEED_W-1:0] next_speed_cmd;
    logic [31:0]                    tick_count, next_tick_count;
    logic                           tick;

    scurve_pkg::shape_type          shape;
    scurve_pkg::ramp_type           ramp;

    logic [scurve_pkg::FINE_W-1:0]  accel_step;
    logic [scurve_pkg::FINE_W-1:0]  progress_step;
    logic [scurve_pkg::FINE_W-1:0]  remaining;
    logic [scurve_pkg::SPEED_W-1:0] speed_offset;

    assign shape.rate = decel_dir ? decel_rate : accel_rate;
    assign shape.jerk = jerk_scale;

    jerk_rate_calc rate_calc (
        .clk_sys (clk_sys),
        .reset   (reset),
        .shape   (shape),
        .ramp    (ramp)
    );

    // One wait state per access; read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign go = avs_write & ~ack & (avs_address == scurve_pkg::CONTROL_ADDR)
                & avs_byteenable[0] & avs_writedata[scurve_pkg::CONTROL_GO_BIT];
    assign busy = (phase != scurve_pkg::PH_IDLE);

    always_comb begin
        next_ack          = (avs_read | avs_write) & ~ack;
        next_accel_rate   = accel_rate;
        next_decel_rate   = decel_rate;
        next_jerk_scale   = jerk_scale;
        next_start_speed  = start_speed;
        next_target_speed = target_speed;
        next_readdata     = avs_readdata;
        // Settings are frozen while a phase runs so the shape stays consistent
        if (avs_write & ~ack & ~busy) begin
            case (avs_address)
                scurve_pkg::ACCEL_ADDR: begin
                    if (avs_byteenable[0]) next_accel_rate[7:0]  = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_accel_rate[15:8] = avs_writedata[15:8];
                end
                scurve_pkg::DECEL_ADDR: begin
                    if (avs_byteenable[0]) next_decel_rate[7:0]  = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_decel_rate[15:8] = avs_writedata[15:8];
                end
                scurve_pkg::JERK_ADDR: begin
                    if (avs_byteenable[0]) next_jerk_scale[7:0]  = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_jerk_scale[15:8] = avs_writedata[15:8];
                end
                scurve_pkg::START_SPEED_ADDR: begin
                    if (avs_byteenable[0]) next_start_speed[7:0]   = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_start_speed[15:8]  = avs_writedata[15:8];
                    if (avs_byteenable[2]) next_start_speed[23:16] = avs_writedata[23:16];
                end
                scurve_pkg::TARGET_ADDR: begin
                    if (avs_byteenable[0]) next_target_speed[7:0]   = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_target_speed[15:8]  = avs_writedata[15:8];
                    if (avs_byteenable[2]) next_target_speed[23:16] = avs_writedata[23:16];
                end
                default: begin
                end
            endcase
        end
        if (avs_read & ~ack) begin
            case (avs_address)
                scurve_pkg::ACCEL_ADDR:       next_readdata = 32'(accel_rate);
                scurve_pkg::DECEL_ADDR:       next_readdata = 32'(decel_rate);
                scurve_pkg::JERK_ADDR:        next_readdata = 32'(jerk_scale);
                scurve_pkg::START_SPEED_ADDR: next_readdata = 32'(start_speed);
                scurve_pkg::TARGET_ADDR:      next_readdata = 32'(target_speed);
                scurve_pkg::STATUS_ADDR: begin
                    next_readdata = 32'h00000000;
                    next_readdata[scurve_pkg::STATUS_BUSY_BIT]  = busy;
                    next_readdata[scurve_pkg::STATUS_DECEL_BIT] = decel_dir;
                    next_readdata[scurve_pkg::STATUS_PHASE_LSB +: 2] = phase;
                end
                scurve_pkg::SPEED_ADDR:       next_readdata = 32'(speed_cmd);
                scurve_pkg::ACCEL_NOW_ADDR:   next_readdata = accel_fine[31:0];
                default:                      next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h00000000;
            accel_rate   <= scurve_pkg::ACCEL_RESET;
            decel_rate   <= scurve_pkg::DECEL_RESET;
            jerk_scale   <= scurve_pkg::JERK_RESET;
            start_speed  <= scurve_pkg::START_RESET;
            target_speed <= scurve_pkg::TARGET_RESET;
        end else begin
            ack          <= next_ack;
            avs_readdata <= next_readdata;
            accel_rate   <= next_accel_rate;
            decel_rate   <= next_decel_rate;
            jerk_scale   <= next_jerk_scale;
            start_speed  <= next_start_speed;
            target_speed <= next_target_speed;
        end
    end

    // Profile engine: works on the magnitude of the speed change, so one
    // sequence serves both directions.
    assign tick          = (tick_count == 32'(TICK_CYCLES - 1));
    assign remaining     = delta_fine - progress;
    assign accel_step    = ramp.jerk_inc;
    assign progress_step = progress + accel_fine;
    assign speed_offset  = scurve_pkg::SPEED_W'(progress / scurve_pkg::FINE_W'(scurve_pkg::FINE_SCALE));

    always_comb begin
        next_tick_count = busy ? (tick ? 32'h00000000 : tick_count + 32'h00000001) : 32'h00000000;
        next_phase      = phase;
        next_decel_dir  = decel_dir;
        next_accel_fine = accel_fine;
        next_progress   = progress;
        next_delta_fine = delta_fine;
        next_ramp_gain  = ramp_gain;
        next_base_speed = base_speed;
        next_speed_cmd  = decel_dir ? base_speed - speed_offset : base_speed + speed_offset;
        case (phase)
            scurve_pkg::PH_IDLE: begin
                next_speed_cmd = speed_cmd;
                if (go && target_speed != start_speed) begin
                    next_decel_dir  = target_speed < start_speed;
                    next_base_speed = start_speed;
                    // Jump to the start speed with go, so no step is taken once busy is up
                    next_speed_cmd  = start_speed;
                    next_delta_fine = scurve_pkg::FINE_W'(next_decel_dir ? start_speed - target_speed
                                                                          : target_speed - start_speed)
                                      * scurve_pkg::FINE_W'(scurve_pkg::FINE_SCALE);
                    next_progress   = '0;
                    next_accel_fine = '0;
                    next_ramp_gain  = '0;
                    next_phase      = scurve_pkg::PH_JERK_UP;
                end
            end
            scurve_pkg::PH_JERK_UP: begin
                if (tick) begin
                    next_progress = progress_step;
                    if (ramp.constant) begin
                        next_accel_fine = ramp.accel_limit;
                        next_phase      = scurve_pkg::PH_HOLD;
                    end else if ((progress_step << 1) >= delta_fine) begin
                        next_ramp_gain = progress_step;
                        next_phase     = scurve_pkg::PH_JERK_DOWN;
                    end else if (accel_fine + accel_step >= ramp.accel_limit) begin
                        next_accel_fine = ramp.accel_limit;
                        next_ramp_gain  = progress_step;
                        next_phase      = scurve_pkg::PH_HOLD;
                    end else begin
                        next_accel_fine = accel_fine + accel_step;
                    end
                end
            end
            scurve_pkg::PH_HOLD: begin
                if (tick) begin
                    next_progress = progress_step;
                    if (progress_step >= delta_fine) begin
                        next_progress  = delta_fine;
                        // Land on target; the offset path lags progress by one cycle
                        next_speed_cmd = target_speed;
                        next_phase     = scurve_pkg::PH_IDLE;
                    end else if (!ramp.constant && delta_fine - progress_step <= ramp_gain) begin
                        next_phase = scurve_pkg::PH_JERK_DOWN;
                    end
                end
            end
            scurve_pkg::PH_JERK_DOWN: begin
                if (tick) begin
                    if (accel_fine >= remaining) begin
                        next_progress   = delta_fine;
                        next_speed_cmd  = target_speed;
                        next_accel_fine = '0;
                        next_phase      = scurve_pkg::PH_IDLE;
                    end else begin
                        next_progress = progress_step;
                        // Keep one jerk step so rounding never stalls the phase
                        if (accel_fine > (accel_step << 1)) begin
                            next_accel_fine = accel_fine - accel_step;
                        end
                    end
                end
            end
            default: begin
                next_phase = scurve_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phase      <= scurve_pkg::PH_IDLE;
            decel_dir  <= 1'b0;
            accel_fine <= '0;
            progress   <= '0;
            delta_fine <= '0;
            ramp_gain  <= '0;
            base_speed <= '0;
            speed_cmd  <= '0;
            tick_count <= 32'h00000000;
        end else begin
            phase      <= next_phase;
            decel_dir  <= next_decel_dir;
            accel_fine <= next_accel_fine;
            progress   <= next_progress;
            delta_fine <= next_delta_fine;
            ramp_gain  <= next_ramp_gain;
            base_speed <= next_base_speed;
            speed_cmd  <= next_speed_cmd;
            tick_count <= next_tick_count;
        end
    end
endmodule : scurve_jerk_accel_profiler
`default_nettype wire

// ### sim/scurve_jerk_accel_profiler_properties.sv
`default_nettype none
module scurve_checker #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic                            clk_sys,
    input wire logic                            reset,
    input wire logic [5:0]                      avs_address,
    input wire logic                            avs_read,
    input wire logic                            avs_write,
    input wire logic [31:0]                     avs_writedata,
    input wire logic [3:0]                      avs_byteenable,
    input wire logic [31:0]                     avs_readdata,
    input wire logic                            avs_waitrequest,
    input wire logic [scurve_pkg::SPEED_W-1:0]  speed_cmd,
    input wire logic                            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rate_max;
    logic [15:0] next_rate_max;
    logic        rate_wr;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Only grows, so it stays a safe upper bound on the per-tick step
    assign rate_wr = avs_write && !avs_waitrequest && !busy
        && (avs_address == scurve_pkg::ACCEL_ADDR || avs_address == scurve_pkg::DECEL_ADDR);
    always_comb begin
        next_rate_max = rate_max;
        if (rate_wr && avs_writedata[15:0] > rate_max) begin
            next_rate_max = avs_writedata[15:0];
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rate_max <= scurve_pkg::DECEL_RESET;
        end else begin
            rate_max <= next_rate_max;
        end
    end
    function automatic logic [23:0] gap(input logic [23:0] a, input logic [23:0] b);
        return (a > b) ? a - b : b - a;
    endfunction : gap
    sequence quiet_tick;
        $stable(speed_cmd)[*8];
    endsequence
    sequence go_written;
        $past(avs_write, 1) || $past(avs_write, 2);
    endsequence
    // Speed jumps to the start value with go; the first tick must then stay flat
    AST_SMOOTH_START: assert property ($rose(busy) |=> quiet_tick)
        else $error("speed moved right after start");
    AST_ONE_STEP_PER_TICK: assert property ($changed(speed_cmd) |=> quiet_tick)
        else $error("speed changed twice within one tick");
    AST_IDLE_HOLD: assert property (!busy && !$past(busy) |-> $stable(speed_cmd))
        else $error("speed changed while idle");
    AST_START_BY_GO: assert property ($rose(busy) |-> go_written)
        else $error("phase started without a bus write");
    // The jump to the start speed is not a profile step
    AST_STEP_LIMIT: assert property ($changed(speed_cmd) && $past(busy)
        |-> gap(speed_cmd, $past(speed_cmd)) <= rate_max)
        else $error("speed step above programmed rate");
    AST_ANSWER_DUE: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus access not answered in time");
    AST_FIRST_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state on first request cycle");
    AST_DATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
endmodule : scurve_checker
`default_nettype wire

// ### sim/scurve_host_model.sv
`default_nettype none
module scurve_host_model (
    input  wire logic        clk_sys,
    output logic [5:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end
    // jerk from phase time in ms
    function automatic logic [15:0] jerk_for(input int num, input int phase_ms);
        return 16'(num * 1000 / phase_ms);
    endfunction : jerk_for
    function automatic logic [15:0] third_accel(input logic [15:0] eq);
        return 16'(eq * 3 / 2);
    endfunction : third_accel
    task automatic bus_write(input logic [5:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_writedata <= ~data;
    endtask : bus_write
    task automatic bus_read(input logic [5:0] addr, output logic [31:0] data);
        @(posedge clk_sys);
        avs_address <= addr;
        avs_read <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        data = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_read
endmodule : scurve_host_model
`default_nettype wire

// ### sim/scurve_jerk_accel_profiler_tb.sv
`default_nettype none
module scurve_jerk_accel_profiler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys;
    logic        reset;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [23:0] speed_cmd;
    logic        busy;
    logic [31:0] v;
    int          fails;
    int          samples_checked;
    int          dmax, dmin, nd, dlast, wrong_way, shape_bad;
    int          dfirst[3];

    always #5 clk_sys = ~clk_sys;

    scurve_host_model host_u (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    scurve_jerk_accel_profiler #(.TICK_CYCLES(10)) dut_u (.clk_sys(clk_sys), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .speed_cmd(speed_cmd), .busy(busy));

    task automatic note_bad(input string msg);
        fails++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask : note_bad

    task automatic close_out;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic do_reset;
        reset <= 1'b1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
    endtask : do_reset

    task automatic load(input logic [5:0] ra, input logic [15:0] rate, input logic [15:0] jerk,
                        input logic [23:0] vs, input logic [23:0] vt);
        host_u.bus_write(ra, {16'h0000, rate});
        host_u.bus_write(scurve_pkg::JERK_ADDR, {16'h0000, jerk});
        host_u.bus_write(scurve_pkg::START_SPEED_ADDR, {8'h00, vs});
        host_u.bus_write(scurve_pkg::TARGET_ADDR, {8'h00, vt});
        host_u.bus_write(scurve_pkg::CONTROL_ADDR, 32'h0000_0001);
    endtask : load

    // Records per-tick speed steps; the final snap is kept out of the shape test
    task automatic run_move(input logic [5:0] ra, input logic [15:0] rate, input logic [15:0] jerk,
                            input logic [23:0] vs, input logic [23:0] vt);
        logic [23:0] last;
        logic [23:0] prev;
        int d;
        int k;
        int down;
        load(ra, rate, jerk, vs, vt);
        last = vs;
        prev = speed_cmd;
        {dmax, nd, dlast, wrong_way, shape_bad, down, k} = '0;
        dmin = 1 << 30;
        while (busy !== 1'b1 && k < 5) begin
            @(posedge clk_sys);
            k++;
        end
        while (busy === 1'b1 && k < 5000) begin
            @(posedge clk_sys);
            k++;
            if (speed_cmd !== prev && speed_cmd !== last) begin
                d = (speed_cmd > last) ? int'(speed_cmd - last) : int'(last - speed_cmd);
                if ((speed_cmd > last) != (vt > vs)) wrong_way++;
                if (nd < 3) dfirst[nd] = d;
                if (busy === 1'b1 && d + 1 < dlast) down = 1;
                else if (busy === 1'b1 && down == 1 && d > dlast + 1) shape_bad++;
                if (busy === 1'b1 && d > dmax) dmax = d;
                if (busy === 1'b1 && d < dmin) dmin = d;
                nd++;
                dlast = d;
                last = speed_cmd;
            end
            prev = speed_cmd;
        end
        if (busy !== 1'b0 || speed_cmd !== vt) note_bad("move did not end on target");
        if (wrong_way != 0) note_bad("speed moved the wrong way");
        samples_checked += 2;
    endtask : run_move

    task automatic t_regs;
        host_u.bus_read(scurve_pkg::ACCEL_ADDR, v);
        if (v !== 32'h0000_0014) note_bad("accel reset value");
        host_u.bus_read(scurve_pkg::DECEL_ADDR, v);
        if (v !== 32'h0000_0019) note_bad("decel reset value");
        host_u.bus_read(scurve_pkg::JERK_ADDR, v);
        if (v !== 32'h0000_0000) note_bad("jerk reset value");
        host_u.bus_read(6'h24, v);
        if (v !== 32'h0000_0000) note_bad("unmapped read not zero");
        samples_checked += 4;
    endtask : t_regs

    task automatic t_linear;
        run_move(scurve_pkg::ACCEL_ADDR, 16'h0014, 16'h0000, 24'h00008D, 24'h000155);
        if (dmax != 20 || dmin != 20 || nd != 10) note_bad("constant rate not linear");
        host_u.bus_read(scurve_pkg::SPEED_ADDR, v);
        if (v !== 32'h0000_0155) note_bad("speed readback wrong");
        samples_checked += 2;
    endtask : t_linear

    task automatic t_triangle;
        run_move(scurve_pkg::ACCEL_ADDR, 16'h0014, host_u.jerk_for(200, 10), 24'h000064, 24'h0000C8);
        if (dfirst[0] != 1 || dfirst[1] != 2 || dfirst[2] != 3) note_bad("jerk ramp wrong");
        if (dmax >= 20 || shape_bad != 0) note_bad("triangular phase wrong");
        samples_checked += 2;
    endtask : t_triangle

    task automatic t_trap;
        run_move(scurve_pkg::ACCEL_ADDR, host_u.third_accel(16'h0014), host_u.jerk_for(300, 50),
                 24'h000064, 24'h00044C);
        if (dmax != 30 || dfirst[0] > 2) note_bad("trapezoid did not hold limit");
        if (shape_bad != 0) note_bad("phase not symmetrical");
        samples_checked += 2;
    endtask : t_trap

    task automatic t_decel;
        fork
            run_move(scurve_pkg::DECEL_ADDR, 16'h0019, 16'h1388, 24'h0007D0, 24'h0001F4);
            begin
                wait (busy === 1'b1);
                // Let the go write release the bus before the next request starts
                @(posedge clk_sys);
                host_u.bus_write(scurve_pkg::ACCEL_ADDR, 32'h0000_0001);
                host_u.bus_read(scurve_pkg::STATUS_ADDR, v);
            end
        join
        if (v[1:0] !== 2'b11 || dmax != 25) note_bad("deceleration phase wrong");
        host_u.bus_read(scurve_pkg::ACCEL_ADDR, v);
        if (v !== 32'h0000_001E) note_bad("write while busy not refused");
        samples_checked += 2;
    endtask : t_decel

    task automatic t_min_jerk;
        load(scurve_pkg::ACCEL_ADDR, 16'h0014, 16'h0001, 24'h000064, 24'h00044C);
        repeat (300) @(posedge clk_sys);
        if (busy !== 1'b1 || speed_cmd !== 24'h000064) note_bad("smallest jerk too fast");
        do_reset();
        @(posedge clk_sys);
        if (busy !== 1'b0 || speed_cmd !== 24'h000000) note_bad("reset did not stop move");
        samples_checked += 2;
    endtask : t_min_jerk

    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        fails = 0;
        samples_checked = 0;
        do_reset();
        t_regs();
        t_linear();
        t_triangle();
        t_trap();
        t_decel();
        t_min_jerk();
        t_regs();
        close_out();
    end

    initial begin
        #300000;
        note_bad("watchdog expired");
        close_out();
    end
endmodule : scurve_jerk_accel_profiler_tb

bind scurve_jerk_accel_profiler scurve_checker #(.TICK_CYCLES(TICK_CYCLES)) checker_u (.clk_sys(clk_sys),
    .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .speed_cmd(speed_cmd), .busy(busy));
`default_nettype wire
